// ### core/dcm_match_regs.sv
// Debug comparator address/data compare registers and match logic
`timescale 1ns/1ns
`default_nettype none

module dcm_match_regs
	import dcm_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_reset_n,
	// Register port
	input  wire logic [REG_ADDR_W-1:0] i_reg_addr,
	input  wire logic [REG_DATA_W-1:0] i_reg_wdata,
	input  wire logic                  i_reg_wr,
	input  wire logic                  i_reg_rd,
	output logic      [REG_DATA_W-1:0] o_reg_rdata,
	// Processor buses under watch
	input  wire logic [CPU_W-1:0]      i_cpu_addr,
	input  wire logic [CPU_W-1:0]      i_cpu_data,
	input  wire logic                  i_cpu_valid,
	// Match results
	output logic      [NUM_CMP-1:0]    o_match,
	output logic                       o_armed
);

	import dcm_pkg::*;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [7:0]         addr_mid [0:NUM_CMP-1];
	logic [7:0]         addr_low [0:NUM_CMP-1];
	logic [7:0]         data_high_compare;
	logic [7:0]         data_low_compare;
	logic [7:0]         data_high_mask;
	logic [7:0]         data_low_mask;
	logic [1:0]         comparator_bank_select;
	logic               armed;
	logic               tag;
	logic               first_cmp_enable;
	logic [NUM_CMP-1:0] cmp_enable;
	logic [NUM_CMP-1:0] raw_hit;
	logic [7:0]         next_rdata;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic bank_hit(input logic [1:0] sel,
		input int unsigned idx);
		bank_hit = (sel == idx[1:0]) && (sel != BANK_NONE);
	endfunction

	function automatic logic data_window_open(input logic [1:0] sel);
		data_window_open = (sel == BANK_FIRST);
	endfunction

	function automatic logic wr_to(input logic [7:0] addr,
		input logic [7:0] ofs, input logic wr);
		wr_to = wr && (addr == ofs);
	endfunction

	logic addr_wr_ok;
	logic data_wr_ok;

	// Arming freezes every pattern so a live match cannot shift
	assign addr_wr_ok = !armed;
	assign data_wr_ok = !armed
		&& data_window_open(comparator_bank_select);

	// ---------------------------------------------------------------
	// Debug control: bank select and arm
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			comparator_bank_select <= RST_BANK;
		end else if (wr_to(i_reg_addr, OFS_DEBUG_CTRL, i_reg_wr)) begin
			comparator_bank_select <= i_reg_wdata[BANK_MSB:BANK_LSB];
		end
	end

	// Always writable, or the unit could never be disarmed
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			armed <= 1'b0;
		end else if (wr_to(i_reg_addr, OFS_DEBUG_CTRL, i_reg_wr)) begin
			armed <= i_reg_wdata[ARM_BIT];
		end
	end

	// ---------------------------------------------------------------
	// First comparator control and enables
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			tag              <= 1'b0;
			first_cmp_enable <= 1'b0;
		end else if (wr_to(i_reg_addr, OFS_FIRST_CMP_CONTROL,
				i_reg_wr)) begin
			tag              <= i_reg_wdata[TAG_BIT];
			first_cmp_enable <= i_reg_wdata[CMP_EN_BIT];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			cmp_enable <= RST_CMP_EN;
		end else if (wr_to(i_reg_addr, OFS_CMP_ENABLE, i_reg_wr)) begin
			cmp_enable <= i_reg_wdata[NUM_CMP-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Address compare bytes, banked per comparator
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				addr_mid[i] <= RST_BYTE;
				addr_low[i] <= RST_BYTE;
			end
		end else if (addr_wr_ok) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				// Bank 11 matches no index, so the write drops
				if (bank_hit(comparator_bank_select, i)) begin
					if (wr_to(i_reg_addr, OFS_ADDR_MID_COMPARE,
							i_reg_wr)) begin
						addr_mid[i] <= i_reg_wdata;
					end
					if (wr_to(i_reg_addr, OFS_ADDR_LOW_COMPARE,
							i_reg_wr)) begin
						addr_low[i] <= i_reg_wdata;
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Data compare and mask bytes, first comparator only
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			data_high_compare <= RST_BYTE;
			data_low_compare  <= RST_BYTE;
		end else if (data_wr_ok) begin
			if (wr_to(i_reg_addr, OFS_DATA_HIGH_COMPARE, i_reg_wr)) begin
				data_high_compare <= i_reg_wdata;
			end
			if (wr_to(i_reg_addr, OFS_DATA_LOW_COMPARE, i_reg_wr)) begin
				data_low_compare <= i_reg_wdata;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			data_high_mask <= RST_BYTE;
			data_low_mask  <= RST_BYTE;
		end else if (data_wr_ok) begin
			if (wr_to(i_reg_addr, OFS_DATA_HIGH_MASK, i_reg_wr)) begin
				data_high_mask <= i_reg_wdata;
			end
			if (wr_to(i_reg_addr, OFS_DATA_LOW_MASK, i_reg_wr)) begin
				data_low_mask <= i_reg_wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// Address patterns, one per comparator
	// ---------------------------------------------------------------
	logic [15:0] addr_pattern [0:NUM_CMP-1];

	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			addr_pattern[i] = {addr_mid[i], addr_low[i]};
		end
	end

	// ---------------------------------------------------------------
	// Comparators
	// ---------------------------------------------------------------
	for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
		logic [15:0] pattern_data;
		logic [15:0] pattern_mask;
		logic        use_data;
		logic        enable;

		if (g == 0) begin : g_first
			assign pattern_data = {data_high_compare,
				data_low_compare};
			assign pattern_mask = {data_high_mask, data_low_mask};
			// Tagged opcodes only care about the address
			assign use_data = !tag;
			assign enable   = first_cmp_enable;
		end else begin : g_addr_only
			// Later comparators never see the data bus
			assign pattern_data = {NO_MASK, NO_MASK};
			assign pattern_mask = {NO_MASK, NO_MASK};
			assign use_data     = 1'b0;
			assign enable       = cmp_enable[g];
		end

		dcm_comparator u_cmp (
			.i_addr_pattern (addr_pattern[g]),
			.i_data_pattern (pattern_data),
			.i_data_mask    (pattern_mask),
			.i_use_data     (use_data),
			.i_enable       (enable),
			.i_bus_addr     (i_cpu_addr),
			.i_bus_data     (i_cpu_data),
			.o_hit          (raw_hit[g])
		);
	end

	// ---------------------------------------------------------------
	// Match outputs
	// ---------------------------------------------------------------
	// Matches are registered, so they appear in the cycle after a live bus cycle seen while armed
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_match <= '0;
		end else begin
			o_match <= raw_hit & {NUM_CMP{i_cpu_valid && armed}};
		end
	end

	assign o_armed = armed;

	// ---------------------------------------------------------------
	// Read decode
	// ---------------------------------------------------------------
	always_comb begin
		next_rdata = READ_ZERO;
		if (i_reg_addr == OFS_DEBUG_CTRL) begin
			next_rdata[BANK_MSB:BANK_LSB] = comparator_bank_select;
			next_rdata[ARM_BIT]           = armed;
		end else if (i_reg_addr == OFS_FIRST_CMP_CONTROL) begin
			next_rdata[TAG_BIT]    = tag;
			next_rdata[CMP_EN_BIT] = first_cmp_enable;
		end else if (i_reg_addr == OFS_CMP_ENABLE) begin
			next_rdata[NUM_CMP-1:0] = cmp_enable;
		end else if (i_reg_addr == OFS_MATCH_STATUS) begin
			next_rdata[NUM_CMP-1:0] = o_match;
		end else if (i_reg_addr == OFS_ADDR_MID_COMPARE) begin
			// Readable whatever the arm state
			for (int i = 0; i < NUM_CMP; i++) begin
				if (bank_hit(comparator_bank_select, i)) begin
					next_rdata = addr_mid[i];
				end
			end
		end else if (i_reg_addr == OFS_ADDR_LOW_COMPARE) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (bank_hit(comparator_bank_select, i)) begin
					next_rdata = addr_low[i];
				end
			end
		end else if (data_window_open(comparator_bank_select)) begin
			// Data registers hide outside bank 00
			if (i_reg_addr == OFS_DATA_HIGH_COMPARE) begin
				next_rdata = data_high_compare;
			end else if (i_reg_addr == OFS_DATA_LOW_COMPARE) begin
				next_rdata = data_low_compare;
			end else if (i_reg_addr == OFS_DATA_HIGH_MASK) begin
				next_rdata = data_high_mask;
			end else if (i_reg_addr == OFS_DATA_LOW_MASK) begin
				next_rdata = data_low_mask;
			end
		end
	end

	// Read data stands for exactly one cycle after the strobe
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_reg_rdata <= READ_ZERO;
		end else if (i_reg_rd) begin
			o_reg_rdata <= next_rdata;
		end else begin
			o_reg_rdata <= READ_ZERO;
		end
	end

endmodule

`default_nettype wire

// ### core/dcm_pkg.sv
// Constants shared by the debug comparator match register block
package dcm_pkg;

	// ---------------------------------------------------------------
	// Register and processor bus geometry, comparator count
	// ---------------------------------------------------------------
	localparam int unsigned REG_ADDR_W = 8;
	localparam int unsigned REG_DATA_W = 8;
	localparam int unsigned CPU_W      = 16;
	localparam int unsigned NUM_CMP    = 3;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CMP_ENABLE        = 8'h24;
	localparam logic [7:0] OFS_MATCH_STATUS      = 8'h25;
	localparam logic [7:0] OFS_DEBUG_CTRL        = 8'h26;
	localparam logic [7:0] OFS_FIRST_CMP_CONTROL = 8'h27;
	localparam logic [7:0] OFS_ADDR_MID_COMPARE  = 8'h2a;
	localparam logic [7:0] OFS_ADDR_LOW_COMPARE  = 8'h2b;
	localparam logic [7:0] OFS_DATA_HIGH_COMPARE = 8'h2c;
	localparam logic [7:0] OFS_DATA_LOW_COMPARE  = 8'h2d;
	localparam logic [7:0] OFS_DATA_HIGH_MASK    = 8'h2e;
	localparam logic [7:0] OFS_DATA_LOW_MASK     = 8'h2f;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int unsigned BANK_LSB    = 0;
	localparam int unsigned BANK_MSB    = 1;
	localparam int unsigned ARM_BIT     = 7;
	localparam int unsigned TAG_BIT     = 5;
	localparam int unsigned CMP_EN_BIT  = 0;

	// ---------------------------------------------------------------
	// Bank select codes
	// ---------------------------------------------------------------
	localparam logic [1:0] BANK_FIRST  = 2'h0;
	localparam logic [1:0] BANK_SECOND = 2'h1;
	localparam logic [1:0] BANK_THIRD  = 2'h2;
	localparam logic [1:0] BANK_NONE   = 2'h3;

	// ---------------------------------------------------------------
	// Reset values, read default and tie-off constants
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [1:0] RST_BANK     = 2'h0;
	localparam logic [2:0] RST_CMP_EN   = 3'h0;
	localparam logic [7:0] READ_ZERO    = 8'h00;
	localparam logic [7:0] NO_MASK      = 8'h00;

endpackage

// ### core/dcm_comparator.sv
// One address/data comparator of the debug match unit
`timescale 1ns/1ns
`default_nettype none

module dcm_comparator (
	// Programmed pattern
	input  wire logic [15:0] i_addr_pattern,
	input  wire logic [15:0] i_data_pattern,
	input  wire logic [15:0] i_data_mask,
	input  wire logic        i_use_data,
	input  wire logic        i_enable,
	// Observed processor buses
	input  wire logic [15:0] i_bus_addr,
	input  wire logic [15:0] i_bus_data,
	// Result
	output logic             o_hit
);

	logic addr_ok;
	logic data_ok;

	// Each pattern bit demands the same level on its bus bit
	assign addr_ok = (i_bus_addr == i_addr_pattern);

	// Mask bit zero lets the data bit take any value
	assign data_ok = !i_use_data ||
		(((i_bus_data ^ i_data_pattern) & i_data_mask) == 16'h0000);

	assign o_hit = i_enable && addr_ok && data_ok;

endmodule

`default_nettype wire

// ### bench/dcm_cpu_model.sv
// Processor bus model driving the watched address and data buses
`timescale 1ns/1ns
`default_nettype none
module dcm_cpu_model
	import dcm_pkg::*;
(
	// Clock and reset
	input  wire logic                      i_mclk,
	input  wire logic                      i_reset_n,
	// Bench request
	input  wire logic                      i_req,
	input  wire logic [dcm_pkg::CPU_W-1:0] i_addr,
	input  wire logic [dcm_pkg::CPU_W-1:0] i_data,
	// Processor buses
	output logic      [dcm_pkg::CPU_W-1:0] o_cpu_addr,
	output logic      [dcm_pkg::CPU_W-1:0] o_cpu_data,
	output logic                           o_cpu_valid
);
	import dcm_pkg::*;
	// Idle cycles invert the bus so a stale pattern never looks valid
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_cpu_addr  <= '0;
			o_cpu_data  <= '0;
			o_cpu_valid <= 1'b0;
		end else begin
			o_cpu_addr  <= i_req ? i_addr : ~o_cpu_addr;
			o_cpu_data  <= i_req ? i_data : ~o_cpu_data;
			o_cpu_valid <= i_req;
		end
	end
endmodule
`default_nettype wire

// ### bench/dcm_match_chk.sv
// Port-level assertions for the debug comparator match registers
`timescale 1ns/1ns
`default_nettype none
module dcm_match_chk
	import dcm_pkg::*;
(
	// Clock and reset
	input  wire logic                           i_mclk,
	input  wire logic                           i_reset_n,
	// Register port
	input  wire logic [dcm_pkg::REG_ADDR_W-1:0] i_reg_addr,
	input  wire logic [dcm_pkg::REG_DATA_W-1:0] i_reg_wdata,
	input  wire logic                           i_reg_wr,
	input  wire logic                           i_reg_rd,
	input  wire logic [dcm_pkg::REG_DATA_W-1:0] o_reg_rdata,
	// Processor buses
	input  wire logic [dcm_pkg::CPU_W-1:0]      i_cpu_addr,
	input  wire logic [dcm_pkg::CPU_W-1:0]      i_cpu_data,
	input  wire logic                           i_cpu_valid,
	// Results
	input  wire logic [dcm_pkg::NUM_CMP-1:0]    o_match,
	input  wire logic                           o_armed
);
	import dcm_pkg::*;
	logic [1:0] bank;
	logic       arm_req;
	logic       ctl_wr;
	assign arm_req = i_reg_wdata[ARM_BIT];
	assign ctl_wr  = i_reg_wr && i_reg_addr == OFS_DEBUG_CTRL;
	// Bank mirror: the window steering is not visible at the ports
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			bank <= RST_BANK;
		end else if (ctl_wr) begin
			bank <= i_reg_wdata[BANK_MSB:BANK_LSB];
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	a_rdata_idle: assert property (
		!$past(i_reg_rd) |-> o_reg_rdata == READ_ZERO)
		else $error("read data without a read strobe");
	a_unmapped_zero: assert property (
		i_reg_rd && !(i_reg_addr inside {[OFS_CMP_ENABLE:OFS_DATA_LOW_MASK]})
		|=> o_reg_rdata == READ_ZERO) else $error("unmapped read not zero");
	a_bank_none: assert property (
		i_reg_rd && bank == BANK_NONE && i_reg_addr inside
		{[OFS_ADDR_MID_COMPARE:OFS_DATA_LOW_MASK]}
		|=> o_reg_rdata == READ_ZERO) else $error("no-bank read not zero");
	a_data_bank: assert property (
		i_reg_rd && bank != BANK_FIRST && i_reg_addr inside
		{[OFS_DATA_HIGH_COMPARE:OFS_DATA_LOW_MASK]}
		|=> o_reg_rdata == READ_ZERO) else $error("data read outside bank");
	a_arm_follows: assert property (
		ctl_wr |=> o_armed == $past(arm_req)) else $error("arm bit lost");
	a_armed_stable: assert property (
		$past(i_reset_n) && !$stable(o_armed) |-> $past(ctl_wr))
		else $error("arm moved alone");
	a_match_armed: assert property (
		o_match != '0 |-> $past(o_armed)) else $error("match while unarmed");
	a_match_valid: assert property (
		o_match != '0 |-> $past(i_cpu_valid)) else $error("match w/o cycle");
	c_first: cover property (o_match[0]);
	c_second: cover property (o_match[1]);
	c_none_rd: cover property (i_reg_rd && bank == BANK_NONE);
endmodule
bind dcm_match_regs dcm_match_chk u_chk (.i_mclk(i_mclk),
	.i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .i_cpu_addr(i_cpu_addr),
	.i_cpu_data(i_cpu_data), .i_cpu_valid(i_cpu_valid),
	.o_match(o_match), .o_armed(o_armed));
`default_nettype wire

// ### bench/test_debug_comparator_match_regs.sv
// Self-checking bench for the debug comparator match registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
	err_count++; $display("Error %0t got %h exp %h", $time, got, exp); end end
module test_debug_comparator_match_regs;
	import dcm_pkg::*;
	logic        clk, rst_n, wr, rd, req, valid, armed;
	logic [7:0]  addr, wdata, rdata;
	logic [15:0] caddr, cdata, raddr, rdat;
	logic [2:0]  match;
	logic [7:0]  dv [4] = '{8'ha5, 8'h3c, 8'hff, 8'h0f};
	int          err_count, tests_run;
	dcm_match_regs u_dut (.i_mclk(clk), .i_reset_n(rst_n), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_cpu_addr(caddr), .i_cpu_data(cdata),
		.i_cpu_valid(valid), .o_match(match), .o_armed(armed));
	dcm_cpu_model u_cpu (.i_mclk(clk), .i_reset_n(rst_n), .i_req(req),
		.i_addr(raddr), .i_data(rdat), .o_cpu_addr(caddr),
		.o_cpu_data(cdata), .o_cpu_valid(valid));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, exp)
	endtask
	task automatic cpu(input logic [15:0] a, d, input logic [2:0] exp);
		@(posedge clk);
		req   <= 1'b1;
		raddr <= a;
		rdat  <= d;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		#1 `CHK(match, exp)
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end
	initial begin
		{rst_n, wr, rd, req, addr, wdata, raddr, rdat} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 8'h2a; a <= 8'h2f; a++) begin
			rreg(8'(a), RST_BYTE);
		end
		for (int b = 0; b < 4; b++) begin
			wreg(OFS_DEBUG_CTRL, 8'(b));
			wreg(OFS_ADDR_MID_COMPARE, 8'h10 + 8'(b));
			wreg(OFS_ADDR_LOW_COMPARE, 8'h20 + 8'(b));
		end
		for (int b = 0; b < 4; b++) begin
			wreg(OFS_DEBUG_CTRL, 8'(b));
			rreg(OFS_ADDR_MID_COMPARE,
				b == 3 ? READ_ZERO : 8'h10 + 8'(b));
			rreg(OFS_ADDR_LOW_COMPARE,
				b == 3 ? READ_ZERO : 8'h20 + 8'(b));
		end
		wreg(OFS_DEBUG_CTRL, {6'h0, BANK_SECOND});
		wreg(OFS_DATA_HIGH_COMPARE, 8'h77);
		rreg(OFS_DATA_HIGH_COMPARE, READ_ZERO);
		wreg(OFS_DEBUG_CTRL, {6'h0, BANK_FIRST});
		rreg(OFS_DATA_HIGH_COMPARE, RST_BYTE);
		for (int i = 0; i < 4; i++) begin
			wreg(OFS_DATA_HIGH_COMPARE + 8'(i), dv[i]);
		end
		for (int i = 0; i < 4; i++) begin
			rreg(OFS_DATA_HIGH_COMPARE + 8'(i), dv[i]);
		end
		wreg(OFS_CMP_ENABLE, 8'h06);
		wreg(OFS_FIRST_CMP_CONTROL, 8'h01);
		wreg(OFS_DEBUG_CTRL, 8'h80);
		#1 `CHK(armed, 1'b1)
		rreg(OFS_DEBUG_CTRL, 8'h80);
		rreg(OFS_CMP_ENABLE, 8'h06);
		wreg(OFS_ADDR_MID_COMPARE, 8'h55);
		wreg(OFS_DATA_LOW_MASK, 8'h55);
		rreg(OFS_ADDR_MID_COMPARE, 8'h10);
		rreg(OFS_DATA_LOW_MASK, 8'h0f);
		cpu(16'h1020, 16'ha57c, 3'b001);
		cpu(16'h1020, 16'ha573, 3'b000);
		cpu(16'h1020, 16'ha47c, 3'b000);
		cpu(16'h1021, 16'ha57c, 3'b000);
		cpu(16'h0020, 16'ha57c, 3'b000);
		cpu(16'h1121, 16'h0000, 3'b010);
		cpu(16'h1222, 16'hffff, 3'b100);
		wreg(OFS_FIRST_CMP_CONTROL, 8'h21);
		rreg(OFS_FIRST_CMP_CONTROL, 8'h21);
		cpu(16'h1020, 16'h0000, 3'b001);
		wreg(OFS_DEBUG_CTRL, 8'h00);
		#1 `CHK(armed, 1'b0)
		cpu(16'h1020, 16'ha57c, 3'b000);
		wreg(OFS_ADDR_MID_COMPARE, 8'h55);
		rreg(OFS_ADDR_MID_COMPARE, 8'h55);
		wreg(OFS_DATA_LOW_MASK, 8'h55);
		rreg(OFS_DATA_LOW_MASK, 8'h55);
		rreg(8'h30, READ_ZERO);
		give_verdict();
	end
endmodule
`default_nettype wire
